// File: verilog/mux_ctrl_pkg.sv
// shared constants and carrier types of the multiplexer switch control block
package mux_ctrl_pkg;
	// ------------------------------------------------------------
	// serial word layout, first bit shifted in is bit 0
	// ------------------------------------------------------------
	localparam int WORD_BITS = 4;
	localparam int POS_SELECT_LOW = 0;
	localparam int POS_SELECT_HIGH = 1;
	localparam int POS_SPARE = 2;
	localparam int POS_OFF = 3;
	localparam int SYNC_STAGES = 2;
	// ------------------------------------------------------------
	// cleared state: both select bits zero, off bit set
	// ------------------------------------------------------------
	localparam logic [3:0] CLEAR_WORD = 4'h8;
	localparam logic [3:0] ALL_OPEN = 4'h0;
	localparam logic [3:0] SW_IN1_A = 4'h1;
	localparam logic [3:0] SW_IN2_A = 4'h2;
	localparam logic [3:0] SW_IN3_B = 4'h4;
	localparam logic [3:0] SW_IN4_B = 4'h8;

	// one latched control word
	typedef struct packed {
		logic off;
		logic spare;
		logic select_high_bit;
		logic select_low_bit;
	} control_word_type;

	// host control pins after synchronisation
	typedef struct packed {
		logic interface_select;
		logic select_low_bit;
		logic select_high_bit;
		logic output_permit;
		logic latch_hold_n;
		logic clear_all_n;
		logic pair_mode;
		logic serial_clk;
		logic chip_select_n;
		logic serial_in;
	} pins_type;

	// switch closures, bit 0 joins input 1 to shared A up to bit 3 input 4 to shared B
	typedef struct packed {
		logic in4_b;
		logic in3_b;
		logic in2_a;
		logic in1_a;
	} switches_type;
endpackage : mux_ctrl_pkg

// File: verilog/mux_switch_control_interface.sv
// control logic that closes switch paths of a four-input, two-output multiplexer
// How it works
// - reset opens every switch like clear does
// - interface select high serial, low parallel
// - four-stage shifter keeps only last four bits
// - bit order: low, high, spare, off last
// - cascade out is fourth stage, per clock
// - shift on clock rise while selected, enabled
// - shifter moves to latches on select rise
// - serial clear opens, clears all, cascade low
// - parallel mode floats the cascade output
// - pair mode ignores high select bit
// - pair mode low gives one-of-four selection
// - parallel latches transparent while hold low
// - parallel clear opens switches, clears latches
// - one-of-four decode of the two selects
// - dual one-of-two decode of low select
// - latched off bit opens every switch
// - cascade of four takes one 16-bit write
`timescale 1ns/1ns
module mux_switch_control_interface (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_interface_select,
	input wire logic i_select_low_bit,
	input wire logic i_select_high_bit,
	input wire logic i_output_permit,
	input wire logic i_latch_hold_n,
	input wire logic i_clear_all_n,
	input wire logic i_pair_mode,
	input wire logic i_serial_clk,
	input wire logic i_chip_select_n,
	input wire logic i_serial_in,
	output logic [3:0] o_switches,
	output logic o_cascade_out,
	output logic o_cascade_out_en
);
	import mux_ctrl_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		pins_type sync1;
		pins_type sync2;
		logic clk_prev;
		logic cs_prev;
		logic [WORD_BITS-1:0] shifter;
		control_word_type latched;
		logic permit_latched;
		switches_type switches;
		logic cascade_en;
	} state_type;

	// synchroniser reset matches the idle chip select level, so no false select rise
	// appears once the stages fill after reset
	localparam pins_type SYNC_IDLE = '{chip_select_n: 1'b1, default: 1'b0};

	state_type state;
	state_type next_state;
	pins_type pins_raw;
	pins_type pins;
	logic clk_rise;
	logic cs_rise;
	logic serial_mode;
	logic pair_now;
	control_word_type word_now;
	logic permit_now;
	switches_type decoded;

	assign pins_raw = '{
		interface_select: i_interface_select,
		select_low_bit: i_select_low_bit,
		select_high_bit: i_select_high_bit,
		output_permit: i_output_permit,
		latch_hold_n: i_latch_hold_n,
		clear_all_n: i_clear_all_n,
		pair_mode: i_pair_mode,
		serial_clk: i_serial_clk,
		chip_select_n: i_chip_select_n,
		serial_in: i_serial_in
	};

	// ------------------------------------------------------------
	// edge detection on the synchronised pins
	// ------------------------------------------------------------
	// only the second stage feeds logic, the first may be metastable
	assign pins = state.sync2;
	assign clk_rise = pins.serial_clk & ~state.clk_prev;
	assign cs_rise = pins.chip_select_n & ~state.cs_prev;
	assign serial_mode = pins.interface_select;
	// pair pin is read live in both modes; in serial the host holds it steady
	assign pair_now = pins.pair_mode;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	always_comb begin
		decoded = switches_type'(ALL_OPEN);
		if (word_now.off || !permit_now) begin
			decoded = switches_type'(ALL_OPEN);
		end else if (pair_now) begin
			// high select bit ignored, both outputs driven together
			if (word_now.select_low_bit) begin
				decoded = switches_type'(SW_IN2_A | SW_IN4_B);
			end else begin
				decoded = switches_type'(SW_IN1_A | SW_IN3_B);
			end
		end else begin
			case ({word_now.select_high_bit, word_now.select_low_bit})
				2'h0: decoded = switches_type'(SW_IN1_A);
				2'h1: decoded = switches_type'(SW_IN2_A);
				2'h2: decoded = switches_type'(SW_IN3_B);
				2'h3: decoded = switches_type'(SW_IN4_B);
				default: decoded = switches_type'(ALL_OPEN);
			endcase
		end
	end

	// ------------------------------------------------------------
	// effective control word per mode
	// ------------------------------------------------------------
	always_comb begin
		word_now = state.latched;
		permit_now = state.permit_latched;
		if (serial_mode) begin
			// permit acts live in serial mode, it is not part of the word
			permit_now = pins.output_permit;
		end else if (!pins.latch_hold_n) begin
			// transparent latches follow the pins
			word_now.select_low_bit = pins.select_low_bit;
			word_now.select_high_bit = pins.select_high_bit;
			word_now.off = 1'b0;
			permit_now = pins.output_permit;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.sync1 = pins_raw;
		next_state.sync2 = state.sync1;
		next_state.clk_prev = pins.serial_clk;
		next_state.cs_prev = pins.chip_select_n;
		next_state.cascade_en = serial_mode;
		if (!pins.clear_all_n) begin
			// clear dominates every other input in both modes
			next_state.latched = control_word_type'(CLEAR_WORD);
			next_state.permit_latched = 1'b1;
			next_state.shifter = '0;
		end else if (serial_mode) begin
			if (clk_rise && !pins.chip_select_n && pins.output_permit) begin
				// new bit enters at the top, so the first bit lands in bit 0
				next_state.shifter = {pins.serial_in, state.shifter[WORD_BITS-1:1]};
			end
			if (cs_rise) begin
				next_state.latched = control_word_type'(state.shifter);
			end
		end else if (!pins.latch_hold_n) begin
			next_state.latched.select_low_bit = pins.select_low_bit;
			next_state.latched.select_high_bit = pins.select_high_bit;
			next_state.latched.off = 1'b0;
			next_state.latched.spare = 1'b0;
			next_state.permit_latched = pins.output_permit;
		end
		if (!pins.clear_all_n) begin
			next_state.switches = switches_type'(ALL_OPEN);
		end else begin
			next_state.switches = decoded;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			// power-up equals the cleared state, all switches open
			state.sync1 <= SYNC_IDLE;
			state.sync2 <= SYNC_IDLE;
			state.clk_prev <= 1'b0;
			state.cs_prev <= 1'b1;
			state.shifter <= '0;
			state.latched <= control_word_type'(CLEAR_WORD);
			state.permit_latched <= 1'b1;
			state.switches <= switches_type'(ALL_OPEN);
			state.cascade_en <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_switches = state.switches;
	// the oldest stage drives the chain, so a 16-bit write fills four parts
	assign o_cascade_out = state.shifter[0];
	assign o_cascade_out_en = state.cascade_en;
endmodule : mux_switch_control_interface

// File: bench/mux_ctrl_assertions.sv
// port assertions of the switch control block
`timescale 1ns/1ns
module mux_ctrl_assertions (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_interface_select,
	input wire logic i_select_low_bit,
	input wire logic i_select_high_bit,
	input wire logic i_output_permit,
	input wire logic i_latch_hold_n,
	input wire logic i_clear_all_n,
	input wire logic i_pair_mode,
	input wire logic i_serial_clk,
	input wire logic i_chip_select_n,
	input wire logic [3:0] o_switches,
	input wire logic o_cascade_out,
	input wire logic o_cascade_out_en
);
	default clocking ck @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	// six samples span both sync stages, the decode and the output register
	sequence par_on;
		(!i_interface_select && !i_latch_hold_n && i_clear_all_n && i_output_permit
			&& $stable({i_pair_mode, i_select_high_bit, i_select_low_bit}))[*6];
	endsequence
	a_reset_open: assert property ($fell(i_reset) |-> o_switches == 4'h0)
		else $error("switch closed out of reset");
	a_mode_drive: assert property ($stable(i_interface_select) [*5] |->
		o_cascade_out_en == i_interface_select) else $error("cascade drive wrong");
	a_par_decode: assert property (par_on |-> o_switches == (i_pair_mode ?
		{i_select_low_bit, !i_select_low_bit, i_select_low_bit, !i_select_low_bit}
		: 4'h1 << {i_select_high_bit, i_select_low_bit})) else $error("decode wrong");
	a_hold_keep: assert property (
		(!i_interface_select && i_latch_hold_n && i_clear_all_n && $stable(i_pair_mode)) [*6]
		|=> $stable(o_switches)) else $error("held latches moved");
	a_clear_open: assert property (!i_clear_all_n [*6] |->
		o_switches == 4'h0 && !(i_interface_select && o_cascade_out)) else $error("clear failed");
	a_permit_open: assert property ((i_interface_select && !i_output_permit) [*6] |->
		o_switches == 4'h0) else $error("permit low ignored");
	a_latch_on_rise: assert property ((i_interface_select && i_output_permit
		&& i_clear_all_n && !$rose(i_chip_select_n)) [*6] |=> $stable(o_switches))
		else $error("switches moved without select rise");
	a_cascade_step: assert property (
		(i_interface_select && i_clear_all_n && !$rose(i_serial_clk)) [*5]
		|=> $stable(o_cascade_out)) else $error("cascade moved without clock rise");
endmodule : mux_ctrl_assertions

// File: bench/host_serial_model.sv
// host side serial master driving the block's serial pins
`timescale 1ns/1ns
module host_serial_model (
	output logic o_serial_clk,
	output logic o_chip_select_n,
	output logic o_serial_in
);
	initial {o_serial_clk, o_chip_select_n, o_serial_in} = 3'h2;
	// clock idles low between frames; data line inverts once released
	task automatic send(input logic [15:0] word);
		o_chip_select_n = 1'b0;
		for (int i = 0; i < 16; i++) begin
			o_serial_in = word[i];
			#62 o_serial_clk = 1'b1;
			#63 o_serial_clk = 1'b0;
		end
		#62 o_chip_select_n = 1'b1;
		o_serial_in = ~o_serial_in;
	endtask : send
endmodule : host_serial_model

// File: bench/mux_switch_control_interface_tb.sv
// self-checking bench of the switch control block
`timescale 1ns/1ns
module mux_switch_control_interface_tb;
	logic i_ref_clk = 1'b0, i_reset = 1'b1, i_interface_select, i_select_low_bit;
	logic i_select_high_bit, i_output_permit, i_latch_hold_n, i_clear_all_n, i_pair_mode;
	logic i_serial_clk, i_chip_select_n, i_serial_in, o_cascade_out, o_cascade_out_en;
	logic [3:0] o_switches;
	logic [6:0] ctl = 7'h0A;
	int fail_count = 0, total_checks = 0;
	// {0, serial, low, high, permit, hold_n, clear_n, pair, switches expected}
	logic [11:0] pt [12] = '{12'h0A1, 12'h2A2, 12'h1A4, 12'h3A8, 12'h1B5, 12'h2BA,
		12'h0FA, 12'h0E2, 12'h220, 12'h2A2, 12'h280, 12'h0E0};
	assign {i_interface_select, i_select_low_bit, i_select_high_bit, i_output_permit,
		i_latch_hold_n, i_clear_all_n, i_pair_mode} = ctl;
	always #5 i_ref_clk = ~i_ref_clk;
	mux_switch_control_interface dut (.*);
	host_serial_model host (.o_serial_clk(i_serial_clk), .o_chip_select_n(i_chip_select_n),
		.o_serial_in(i_serial_in));
	task automatic chk(input logic [4:0] got, input logic [4:0] want);
		total_checks++;
		if (got !== want) begin
			fail_count++;
			$display("Error %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	// wait out both sync stages, the decode and the output register
	task automatic put(input logic [6:0] v);
		@(posedge i_ref_clk);
		#1 ctl = v;
		repeat (8) @(posedge i_ref_clk);
		#1;
	endtask : put
	task automatic sw(input logic [15:0] w, input logic [4:0] e);
		host.send(w);
		put(7'h4A); // pair pin held low in serial mode
		chk({o_switches, o_cascade_out}, e);
	endtask : sw
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	initial begin
		repeat (2) @(posedge i_ref_clk);
		#1 chk({o_switches, o_cascade_out_en}, 5'h00);
		i_reset = 1'b0;
		for (int i = 0; i < 12; i++) begin
			put(pt[i][10:4]);
			chk({o_switches, o_cascade_out_en}, {pt[i][3:0], 1'b0});
		end
		$display("parallel test done");
		put(7'h48);
		chk({o_switches, o_cascade_out}, 5'h00);
		chk({4'h0, o_cascade_out_en}, 5'h01);
		put(7'h4A);
		sw(16'h3A51, 5'h11);
		sw(16'h2000, 5'h08);
		put(7'h42);
		chk({o_switches, o_cascade_out}, 5'h00);
		sw(16'h3000, 5'h08);
		sw(16'hB000, 5'h01);
		$display("serial test done");
		close_out();
	end
endmodule : mux_switch_control_interface_tb
bind mux_switch_control_interface mux_ctrl_assertions checks (.*);
